// file: vap_pkg.sv
package vap_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_MODE_CONFIG_TWO = 8'h0C;
    localparam logic [7:0] IDX_NOLOAD_MODE = 8'h0E;
    localparam logic [7:0] IDX_ACCUMULATION_MODE = 8'h0F;
    localparam logic [7:0] IDX_IRQEN = 8'hD9;
    localparam logic [7:0] IDX_IRQST = 8'hDC;
    localparam logic [7:0] IDX_VOLTAGE_RMS_RESULT = 8'h10;
    localparam logic [7:0] IDX_VOLTAGE_RMS_OFFSET = 8'h11;
    localparam logic [7:0] IDX_GAIN = 8'h12;
    localparam logic [7:0] IDX_PWROS = 8'h13;
    localparam logic [7:0] IDX_APWR = 8'h14;
    // field positions
    localparam int ZX_RMS_BIT = 0;
    localparam int SIGN_SEL_BIT = 3;
    localparam int NL_FIELD_LSB = 0;
    localparam int ST_NOLOAD_BIT = 0;
    localparam int ST_SIGN_BIT = 2;
    // processing rate is one fifth of the master clock
    localparam logic [2:0] DIV_LAST = 3'h4;
    // scaling constants
    localparam int VOLTAGE_RMS_RESULT_OS_SHIFT = 6;
    localparam int GAIN_SHIFT = 12;
    localparam int PWR_FRAC_SHIFT = 8;
    localparam int VLPF_SHIFT = 10;
    localparam int PLPF_SHIFT = 10;
    // rms reading for a full-scale sine, a test reference only
    localparam logic [23:0] VOLTAGE_RMS_RESULT_FULL_SCALE_REF = 24'h1CF68C;
    // no-load thresholds against a 2^38 full-scale calibrated power
    localparam logic [63:0] PWR_FS = 64'h40_0000_0000;
    localparam logic [39:0] NL_THR1 = 40'(PWR_FS * 64'hF / 64'h186A0);
    localparam logic [39:0] NL_THR2 = 40'(PWR_FS * 64'h4B / 64'hF4240);
    localparam logic [39:0] NL_THR3 = 40'(PWR_FS * 64'h25 / 64'hF4240);
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: vap_power_rms.sv
`timescale 1ns/1ps
// How it works
// [RL1] rms from voltage samples, 24-bit unsigned, readable
// [RL2] rms refreshed every fifth clock
// [RL3] zero-cross mode: refresh only at crossings
// [RL4] full-scale sine reads about reference code
// [RL5] add 64 times signed offset to rms
// [RL6] power is low-passed current times voltage
// [RL7] scale power by one plus gain/4096
// [RL8] add signed offset, 256 counts per LSB
// [RL9] default: flag positive to negative change
// [RL10] select bit set: flag negative to positive
// [RL11] enabled sign flag holds interrupt until cleared
// [RL12] below threshold: stop accumulation, set no-load
// [RL13] enabled no-load flag holds interrupt until cleared
// [RL14] two-bit field picks threshold, 00 disables
// [RL15] flag only true sign change between samples
module vap_power_rms
    import vap_pkg::*;
#(
    parameter int SW = 24,
    parameter int ADDR_W = 10
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic [SW-1:0] voltSample,
    input wire logic [SW-1:0] curSample,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    output logic energyAccEn,
    output logic [2*SW-PWR_FRAC_SHIFT-1:0] activePower
);
    localparam int P_W = 2 * SW; // squared and product width
    localparam int AP_W = P_W - PWR_FRAC_SHIFT; // calibrated power width
    localparam int IX_W = ADDR_W - 2; // word index width

    // every flip-flop of the block
    typedef struct packed {
        logic awready;
        logic wready;
        logic awHeld;
        logic [IX_W-1:0] awIdx;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] mode_config_two;
        logic [7:0] noload_mode;
        logic [7:0] accumulation_mode;
        logic [7:0] irqEn;
        logic [7:0] irqSt;
        logic [11:0] voltage_rms_offset;
        logic [11:0] gain;
        logic [15:0] pwrOs;
        logic [2:0] divCnt;
        logic [P_W-1:0] vMs;
        logic [SW-1:0] voltage_rms_result;
        logic prevVSign;
        logic [P_W-1:0] pLpf;
        logic [AP_W-1:0] actPower;
        logic prevPSign;
        logic pValid;
        logic accEn;
        logic irq;
    } vap_state_s;

    vap_state_s st; // registered state
    vap_state_s n; // next state

    // one-pole low-pass; an extra bit keeps the difference from wrapping
    function automatic logic signed [P_W-1:0] lpfStep(
        input logic signed [P_W-1:0] s,
        input logic signed [P_W-1:0] x,
        input int sh
    );
        logic signed [P_W:0] diff;
        diff = {x[P_W-1], x} - {s[P_W-1], s};
        return P_W'({s[P_W-1], s} + (diff >>> sh));
    endfunction

    // bitwise integer square root, unrolled over SW steps
    function automatic logic [SW-1:0] isqrt(input logic [P_W-1:0] x);
        logic [P_W-1:0] rem;
        logic [P_W-1:0] res;
        logic [P_W-1:0] bitv;
        rem = x;
        res = '0;
        bitv = P_W'(1) << (2 * (SW - 1));
        for (int i = 0; i < SW; i++) begin
            if (rem >= res + bitv) begin
                rem = rem - (res + bitv);
                res = (res >> 1) + bitv;
            end else begin
                res = res >> 1;
            end
            bitv = bitv >> 2;
        end
        return res[SW-1:0];
    endfunction

    // merge write data into a register under the byte strobes
    function automatic logic [31:0] applyStrb(
        input logic [31:0] old,
        input logic [31:0] dat,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return r;
    endfunction

    logic tick; // one processing sample every fifth clock
    logic signed [SW-1:0] vs; // voltage sample
    logic signed [SW-1:0] cs; // current sample
    logic signed [P_W-1:0] sq; // squared voltage
    logic signed [P_W-1:0] msNext; // next mean square
    logic [SW-1:0] root; // uncorrected rms
    logic signed [SW+1:0] osExt; // rms offset, widened
    logic signed [SW+1:0] corr; // offset-corrected rms
    logic [SW-1:0] vrmsNew; // clamped result
    logic zx; // voltage sign changed
    logic signed [P_W-1:0] prod; // instantaneous power
    logic signed [P_W-1:0] pNext; // next filtered power
    logic signed [AP_W-1:0] base; // filtered power, 8 fraction bits
    logic signed [AP_W+12:0] ext; // widened for the gain product
    logic signed [AP_W+12:0] scaled; // gain applied
    logic signed [AP_W-1:0] gained; // gain-calibrated power
    logic signed [AP_W-1:0] withOs; // fully calibrated power
    logic [AP_W-1:0] mag; // magnitude for no-load test
    logic [AP_W-1:0] thr; // selected no-load threshold
    logic [1:0] nlField; // threshold select
    logic noLoadNow; // below threshold this sample
    logic newSign; // sign of calibrated power
    logic signEv; // qualifying sign change
    logic [7:0] setBits; // status events this cycle
    logic [7:0] clrBits; // status bits software clears
    logic wrGo; // address and data both held
    logic wrHit; // write index is mapped
    logic [31:0] wv; // strobe-merged write value
    logic [IX_W-1:0] rdIdx; // read index
    logic [31:0] rd; // read mux
    logic rdHit; // read index is mapped

    // datapath and bus slave, next-state logic
    always_comb begin
        n = st;
        tick = (st.divCnt == DIV_LAST);
        n.divCnt = tick ? 3'h0 : st.divCnt + 3'h1; // [RL2]
        vs = signed'(voltSample);
        cs = signed'(curSample);
        // mean square of the waveform samples, then root [RL1]
        sq = vs * vs;
        msNext = lpfStep(signed'(st.vMs), sq, VLPF_SHIFT);
        root = isqrt(msNext); // [RL4]
        // offset of 64 lsb per count; clamp keeps it unsigned [RL5]
        osExt = (SW+2)'(signed'(st.voltage_rms_offset));
        corr = signed'({2'b00, root}) + (osExt <<< VOLTAGE_RMS_RESULT_OS_SHIFT);
        if (corr[SW+1]) begin
            vrmsNew = '0;
        end else if (corr[SW]) begin
            vrmsNew = '1;
        end else begin
            vrmsNew = corr[SW-1:0];
        end
        zx = (vs[SW-1] != st.prevVSign);
        // power is the filtered product of the two channels [RL6]
        prod = vs * cs;
        pNext = lpfStep(signed'(st.pLpf), prod, PLPF_SHIFT);
        base = AP_W'(pNext >>> PWR_FRAC_SHIFT);
        ext = (AP_W+13)'(base);
        scaled = ext + ((ext * (AP_W+13)'(signed'(st.gain))) >>> GAIN_SHIFT);
        gained = AP_W'(scaled); // [RL7]
        withOs = gained + AP_W'(signed'(st.pwrOs)); // [RL8]
        // no-load judged on the calibrated multiplier output
        mag = gained[AP_W-1] ? AP_W'(-gained) : AP_W'(gained);
        nlField = st.noload_mode[NL_FIELD_LSB +: 2];
        unique case (nlField)
            2'h1: thr = NL_THR1;
            2'h2: thr = NL_THR2;
            2'h3: thr = NL_THR3;
            default: thr = '0;
        endcase
        noLoadNow = (nlField != 2'h0) && (mag < thr); // [RL14]
        newSign = withOs[AP_W-1];
        // first sample after reset has no sign to compare to [RL15]
        signEv = tick && st.pValid && (newSign != st.prevPSign)
            && (st.accumulation_mode[SIGN_SEL_BIT] ? !newSign : newSign); // [RL9] [RL10]
        if (tick) begin
            n.vMs = msNext;
            n.prevVSign = vs[SW-1];
            if (!st.mode_config_two[ZX_RMS_BIT] || zx) begin
                n.voltage_rms_result = vrmsNew; // [RL3]
            end
            n.pLpf = pNext;
            n.actPower = withOs;
            n.prevPSign = newSign;
            n.pValid = 1'b1;
            n.accEn = !noLoadNow; // [RL12]
        end
        setBits = '0;
        setBits[ST_SIGN_BIT] = signEv;
        setBits[ST_NOLOAD_BIT] = tick && noLoadNow; // [RL12]
        clrBits = '0;

        // write channel: address and data are taken in either order
        if (st.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (awvalid && st.awready) begin
            n.awHeld = 1'b1;
            n.awIdx = awaddr[ADDR_W-1:2];
        end
        if (wvalid && st.wready) begin
            n.wHeld = 1'b1;
            n.wData = wdata;
            n.wStrb = wstrb;
        end
        wrGo = st.awHeld && st.wHeld && !st.bvalid;
        wrHit = 1'b0;
        wv = '0;
        if (wrGo) begin
            n.awHeld = 1'b0;
            n.wHeld = 1'b0;
            n.bvalid = 1'b1;
            wrHit = 1'b1;
            case (st.awIdx)
                IDX_MODE_CONFIG_TWO: begin
                    wv = applyStrb(32'(st.mode_config_two), st.wData, st.wStrb);
                    n.mode_config_two = wv[7:0];
                end
                IDX_NOLOAD_MODE: begin
                    wv = applyStrb(32'(st.noload_mode), st.wData, st.wStrb);
                    n.noload_mode = wv[7:0];
                end
                IDX_ACCUMULATION_MODE: begin
                    wv = applyStrb(32'(st.accumulation_mode), st.wData, st.wStrb);
                    n.accumulation_mode = wv[7:0];
                end
                IDX_IRQEN: begin
                    wv = applyStrb(32'(st.irqEn), st.wData, st.wStrb);
                    n.irqEn = wv[7:0];
                end
                IDX_IRQST: begin
                    // write one to clear
                    clrBits = st.wData[7:0] & {8{st.wStrb[0]}};
                end
                IDX_VOLTAGE_RMS_OFFSET: begin
                    wv = applyStrb(32'(st.voltage_rms_offset), st.wData, st.wStrb);
                    n.voltage_rms_offset = wv[11:0];
                end
                IDX_GAIN: begin
                    wv = applyStrb(32'(st.gain), st.wData, st.wStrb);
                    n.gain = wv[11:0];
                end
                IDX_PWROS: begin
                    wv = applyStrb(32'(st.pwrOs), st.wData, st.wStrb);
                    n.pwrOs = wv[15:0];
                end
                // read-only results ignore writes but answer okay
                IDX_VOLTAGE_RMS_RESULT, IDX_APWR: wrHit = 1'b1;
                default: wrHit = 1'b0;
            endcase
            n.bresp = wrHit ? RESP_OKAY : RESP_SLVERR;
        end
        // set wins over a clear in the same cycle [RL11] [RL13]
        n.irqSt = (st.irqSt & ~clrBits) | setBits;
        n.awready = !n.awHeld && !n.bvalid;
        n.wready = !n.wHeld && !n.bvalid;

        // read channel, one outstanding read
        rdIdx = araddr[ADDR_W-1:2];
        rdHit = 1'b1;
        unique case (rdIdx)
            IDX_MODE_CONFIG_TWO: rd = 32'(st.mode_config_two);
            IDX_NOLOAD_MODE: rd = 32'(st.noload_mode);
            IDX_ACCUMULATION_MODE: rd = 32'(st.accumulation_mode);
            IDX_IRQEN: rd = 32'(st.irqEn);
            IDX_IRQST: rd = 32'(st.irqSt);
            IDX_VOLTAGE_RMS_RESULT: rd = 32'(st.voltage_rms_result); // [RL1]
            IDX_VOLTAGE_RMS_OFFSET: rd = 32'(st.voltage_rms_offset);
            IDX_GAIN: rd = 32'(st.gain);
            IDX_PWROS: rd = 32'(st.pwrOs);
            // upper 32 bits: whole waveform lsb units and above
            IDX_APWR: rd = st.actPower[AP_W-1 -: 32];
            default: begin
                rd = '0;
                rdHit = 1'b0;
            end
        endcase
        if (st.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && st.arready) begin
            n.rvalid = 1'b1;
            n.rdata = rd;
            n.rresp = rdHit ? RESP_OKAY : RESP_SLVERR;
        end
        n.arready = !n.rvalid;
        // level interrupt while any enabled status bit stands
        n.irq = |(n.irqSt & n.irqEn); // [RL11] [RL13]
    end

    // state register; clock enable freezes everything
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st <= '0;
        end else if (clkEn) begin
            st <= n;
        end
    end

    assign awready = st.awready;
    assign wready = st.wready;
    assign bresp = st.bresp;
    assign bvalid = st.bvalid;
    assign arready = st.arready;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign rvalid = st.rvalid;
    assign irq = st.irq;
    assign energyAccEn = st.accEn;
    assign activePower = st.actPower;

    // checks on the datapath; frozen cycles are excluded
    property p_rate;
        @(posedge sys_clk) disable iff (!resetn || !clkEn)
        tick |=> !tick [*4] ##1 tick;
    endproperty
    a_rate: assert property (p_rate) else $error("tick spacing wrong"); // [RL2]

    property p_vchg;
        @(posedge sys_clk) disable iff (!resetn || !clkEn)
        $changed(st.voltage_rms_result) |-> $past(tick);
    endproperty
    a_vchg: assert property (p_vchg) else $error("rms moved off tick"); // [RL2]

    property p_zx;
        @(posedge sys_clk) disable iff (!resetn || !clkEn)
        tick && st.mode_config_two[ZX_RMS_BIT] && !zx |=> $stable(st.voltage_rms_result);
    endproperty
    a_zx: assert property (p_zx) else $error("rms updated off crossing"); // [RL3]

    property p_rms;
        @(posedge sys_clk) disable iff (!resetn || !clkEn)
        tick && !st.mode_config_two[ZX_RMS_BIT] && st.voltage_rms_offset == 12'h000
            |=> st.voltage_rms_result == $past(root);
    endproperty
    a_rms: assert property (p_rms) else $error("rms not root"); // [RL1] [RL5]

    property p_pwr;
        @(posedge sys_clk) disable iff (!resetn || !clkEn)
        tick && st.gain == 12'h000 |=>
            st.actPower == AP_W'($past(base) + AP_W'(signed'($past(st.pwrOs))));
    endproperty
    a_pwr: assert property (p_pwr) else $error("power offset wrong"); // [RL6] [RL8]

    property p_neg;
        @(posedge sys_clk) disable iff (!resetn || !clkEn)
        tick && st.pValid && !st.accumulation_mode[SIGN_SEL_BIT] && !st.prevPSign
            && newSign |=> st.irqSt[ST_SIGN_BIT];
    endproperty
    a_neg: assert property (p_neg) else $error("missed pos to neg"); // [RL9]

    property p_pos;
        @(posedge sys_clk) disable iff (!resetn || !clkEn)
        tick && st.pValid && st.accumulation_mode[SIGN_SEL_BIT] && st.prevPSign
            && !newSign |=> st.irqSt[ST_SIGN_BIT];
    endproperty
    a_pos: assert property (p_pos) else $error("missed neg to pos"); // [RL10]

    property p_src;
        @(posedge sys_clk) disable iff (!resetn || !clkEn)
        !$past(st.irqSt[ST_SIGN_BIT]) && st.irqSt[ST_SIGN_BIT]
            |-> $past(tick) && $past(st.pValid);
    endproperty
    a_src: assert property (p_src) else $error("sign flag w/o change"); // [RL15]

    property p_irq;
        @(posedge sys_clk) disable iff (!resetn || !clkEn)
        st.irqSt[ST_SIGN_BIT] && st.irqEn[ST_SIGN_BIT]
            || st.irqSt[ST_NOLOAD_BIT] && st.irqEn[ST_NOLOAD_BIT] |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt dropped"); // [RL11] [RL13]

    property p_nl;
        @(posedge sys_clk) disable iff (!resetn || !clkEn)
        tick && noLoadNow |=> !energyAccEn && st.irqSt[ST_NOLOAD_BIT];
    endproperty
    a_nl: assert property (p_nl) else $error("no-load not taken"); // [RL12]

    property p_nloff;
        @(posedge sys_clk) disable iff (!resetn || !clkEn)
        tick && nlField == 2'h0 |=> energyAccEn;
    endproperty
    a_nloff: assert property (p_nloff) else $error("no-load not off"); // [RL14]
endmodule

// file: vap_power_rms_tb.sv
`timescale 1ns/1ps
module vap_power_rms_tb;
    import vap_pkg::*;
    // clock, reset and the two sample streams
    logic sys_clk;
    logic resetn;
    logic clkEn;
    logic [23:0] voltSample;
    logic [23:0] curSample;
    // register bus, names as the bus publishes them
    logic [9:0] awaddr;
    logic [9:0] araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    // block outputs
    logic irq;
    logic energyAccEn;
    logic [39:0] activePower;
    // bookkeeping of the run
    int miscompares;
    int totalChecks;

    vap_power_rms DUT (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn),
        .voltSample(voltSample), .curSample(curSample), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irq(irq), .energyAccEn(energyAccEn),
        .activePower(activePower));

    // free-running 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // verdict in one place; every path ends here
    task report_and_stop;
        if (miscompares == 0 && totalChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // case equality so an unknown never passes
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // window check for filtered values that drift slowly between reads
    task automatic chk_rng(input logic signed [47:0] got,
        input logic signed [47:0] lo, input logic signed [47:0] hi);
        totalChecks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("Error at %0t: got %0h expected %0h", $time, got, lo);
        end
    endtask

    // a wait that ran out is a mismatch and closes the run
    task automatic wait_limit(input int n);
        if (n > 100) begin
            miscompares++;
            $display("Error at %0t: got %0h expected %0h", $time, n, 0);
            report_and_stop();
        end
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic bus_write(input logic [7:0] idx, input logic [31:0] dat,
        output logic [1:0] resp);
        int n;
        n = 0;
        awaddr <= {idx, 2'h0};
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(posedge sys_clk);
            n++;
            wait_limit(n);
            if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                break;
            end
        end
    endtask

    // read: address held until taken, data taken at the rvalid edge
    task automatic bus_read(input logic [7:0] idx, output logic [31:0] dat,
        output logic [1:0] resp);
        int n;
        n = 0;
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        forever begin
            @(posedge sys_clk);
            n++;
            wait_limit(n);
            if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                dat = rdata;
                resp = rresp;
                break;
            end
        end
    endtask

    // shorthands: checked write response and checked read
    task automatic wr(input logic [7:0] idx, input logic [31:0] dat,
        input logic [1:0] er);
        logic [1:0] r;
        bus_write(idx, dat, r);
        chk(40'(r), 40'(er));
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
        input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        bus_read(idx, d, r);
        chk(40'(d), 40'(exp));
        chk(40'(r), 40'(er));
    endtask

    // two ticks of the one-in-five processing rate, plus margin
    task automatic ticks2;
        repeat (12) @(posedge sys_clk);
    endtask

    // reset contents, unmapped place, read-only result
    task automatic test_reset;
        logic [7:0] ids [10];
        ids = '{IDX_MODE_CONFIG_TWO, IDX_NOLOAD_MODE, IDX_ACCUMULATION_MODE, IDX_IRQEN, IDX_IRQST,
            IDX_VOLTAGE_RMS_RESULT, IDX_VOLTAGE_RMS_OFFSET, IDX_GAIN, IDX_PWROS, IDX_APWR};
        foreach (ids[i]) rd_chk(ids[i], 32'h0, RESP_OKAY);
        chk(40'(irq), 40'h0);
        rd_chk(8'h20, 32'h0, RESP_SLVERR);
        wr(8'h20, 32'h1, RESP_SLVERR);
        wr(IDX_VOLTAGE_RMS_RESULT, 32'hFFFFFF, RESP_OKAY);
        ticks2();
        rd_chk(IDX_VOLTAGE_RMS_RESULT, 32'h0, RESP_OKAY);
    endtask

    // widths of four writable registers; unused high bits read zero
    task automatic test_regs;
        logic [7:0] ids [4];
        logic [31:0] wv [4];
        logic [31:0] ev [4];
        ids = '{IDX_NOLOAD_MODE, IDX_GAIN, IDX_PWROS, IDX_VOLTAGE_RMS_OFFSET};
        wv = '{32'hFFFFFF00, 32'hFFFFF7FF, 32'h12345678, 32'h00000ABC};
        ev = '{32'h0, 32'h7FF, 32'h5678, 32'hABC};
        foreach (ids[i]) begin
            wr(ids[i], wv[i], RESP_OKAY);
            rd_chk(ids[i], ev[i], RESP_OKAY);
            wr(ids[i], 32'h0, RESP_OKAY);
        end
    endtask

    // offset steps of 64, clamping, and zero-crossing-only refresh
    task automatic test_rms;
        wr(IDX_VOLTAGE_RMS_OFFSET, 32'h010, RESP_OKAY);
        ticks2();
        rd_chk(IDX_VOLTAGE_RMS_RESULT, 32'h400, RESP_OKAY);
        wr(IDX_VOLTAGE_RMS_OFFSET, 32'hFF0, RESP_OKAY);
        ticks2();
        rd_chk(IDX_VOLTAGE_RMS_RESULT, 32'h0, RESP_OKAY);
        wr(IDX_VOLTAGE_RMS_OFFSET, 32'h7FF, RESP_OKAY);
        ticks2();
        rd_chk(IDX_VOLTAGE_RMS_RESULT, 32'h1FFC0, RESP_OKAY);
        wr(IDX_MODE_CONFIG_TWO, 32'h1, RESP_OKAY);
        wr(IDX_VOLTAGE_RMS_OFFSET, 32'h020, RESP_OKAY);
        repeat (30) @(posedge sys_clk);
        rd_chk(IDX_VOLTAGE_RMS_RESULT, 32'h1FFC0, RESP_OKAY);
        voltSample <= 24'hFFFFFF;
        ticks2();
        rd_chk(IDX_VOLTAGE_RMS_RESULT, 32'h800, RESP_OKAY);
        voltSample <= 24'h0;
        wr(IDX_MODE_CONFIG_TWO, 32'h0, RESP_OKAY);
        wr(IDX_VOLTAGE_RMS_OFFSET, 32'h0, RESP_OKAY);
    endtask

    // every threshold setting with zero power, then mask and clear
    task automatic test_noload;
        wr(IDX_IRQEN, 32'h1, RESP_OKAY);
        for (int f = 1; f < 4; f++) begin
            wr(IDX_NOLOAD_MODE, 32'h0, RESP_OKAY);
            ticks2();
            chk(40'(energyAccEn), 40'h1);
            wr(IDX_IRQST, 32'h1, RESP_OKAY);
            rd_chk(IDX_IRQST, 32'h0, RESP_OKAY);
            wr(IDX_NOLOAD_MODE, 32'(f), RESP_OKAY);
            ticks2();
            chk(40'(energyAccEn), 40'h0);
            rd_chk(IDX_IRQST, 32'h1, RESP_OKAY);
            chk(40'(irq), 40'h1);
        end
        wr(IDX_NOLOAD_MODE, 32'h0, RESP_OKAY);
        ticks2();
        chk(40'(irq), 40'h1);
        wr(IDX_IRQEN, 32'h0, RESP_OKAY);
        chk(40'(irq), 40'h0);
        wr(IDX_IRQEN, 32'h1, RESP_OKAY);
        wr(IDX_IRQST, 32'h1, RESP_OKAY);
        chk(40'(irq), 40'h0);
    endtask

    // power sign steps made with the offset alone, samples held at zero
    task automatic test_sign;
        logic s [5];
        logic [15:0] o1 [5];
        logic [15:0] o2 [5];
        logic e [5];
        s = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        o1 = '{16'h0100, 16'hFF00, 16'h0100, 16'h0100, 16'hFF00};
        o2 = '{16'hFF00, 16'h0100, 16'h0200, 16'hFF00, 16'h0100};
        e = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        wr(IDX_IRQEN, 32'h4, RESP_OKAY);
        foreach (s[i]) begin
            wr(IDX_ACCUMULATION_MODE, {28'h0, s[i], 3'h0}, RESP_OKAY);
            wr(IDX_PWROS, 32'(o1[i]), RESP_OKAY);
            ticks2();
            wr(IDX_IRQST, 32'h4, RESP_OKAY);
            wr(IDX_PWROS, 32'(o2[i]), RESP_OKAY);
            ticks2();
            chk(activePower, {{24{o2[i][15]}}, o2[i]});
            rd_chk(IDX_APWR, {{24{o2[i][15]}}, o2[i][15:8]}, RESP_OKAY);
            rd_chk(IDX_IRQST, {29'h0, e[i], 2'h0}, RESP_OKAY);
            chk(40'(irq), 40'(e[i]));
        end
        wr(IDX_IRQST, 32'h4, RESP_OKAY);
        chk(40'(irq), 40'h0);
        wr(IDX_ACCUMULATION_MODE, 32'h0, RESP_OKAY);
        wr(IDX_PWROS, 32'h0, RESP_OKAY);
    endtask

    // clock enable low: samples move but nothing may update
    task automatic test_freeze;
        ticks2();
        clkEn <= 1'b0;
        voltSample <= 24'h100000;
        curSample <= 24'h100000;
        repeat (20) @(posedge sys_clk);
        chk(activePower, 40'h0);
        clkEn <= 1'b1;
        ticks2();
        chk_rng(48'(signed'(activePower)), 48'sd1, 48'sh7FFFFFFFFF);
    endtask

    // real product through the filter, then both gain extremes
    task automatic test_gain;
        logic signed [47:0] p0;
        logic signed [47:0] p;
        logic [31:0] d;
        logic [1:0] r;
        voltSample <= 24'h100000;
        curSample <= 24'h100000;
        // long settle so the filter drifts little between the three reads
        repeat (5000) @(posedge sys_clk);
        p0 = 48'(signed'(activePower));
        chk_rng(p0, 48'sd1, 48'sh7FFFFFFFFF);
        bus_read(IDX_VOLTAGE_RMS_RESULT, d, r);
        chk_rng(48'(d), 48'sd1, 48'shFFFFFF);
        wr(IDX_GAIN, 32'h800, RESP_OKAY);
        ticks2();
        p = 2 * 48'(signed'(activePower));
        chk_rng(p, p0 - p0 / 50, p0 + p0 / 50);
        wr(IDX_GAIN, 32'h7FF, RESP_OKAY);
        ticks2();
        p = 2 * 48'(signed'(activePower));
        chk_rng(p, 3 * p0 - p0 / 16, 3 * p0 + p0 / 16);
    endtask

    // main sequence: values at time zero, five-cycle reset, scenarios
    initial begin
        miscompares = 0;
        totalChecks = 0;
        resetn = 1'b0;
        clkEn = 1'b1;
        voltSample = 24'h0;
        curSample = 24'h0;
        awaddr = 10'h0;
        araddr = 10'h0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        wdata = 32'h0;
        // strobes and response readies stay up for the whole run
        wstrb = 4'hF;
        bready = 1'b1;
        rready = 1'b1;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        test_reset();
        test_regs();
        test_rms();
        test_noload();
        test_sign();
        test_freeze();
        test_gain();
        report_and_stop();
    end
endmodule
